//--- shared/srp_defines.vh
// Purpose: Constants of the serial register port: offsets, fields, resets, counts.
// Assumes: Included by the serial register port design files only.
// Notes: Definitions only; no logic lives here.
`ifndef SRP_DEFINES_VH
`define SRP_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define SRP_ADDR_W 15
`define SRP_OFF_INTERFACE_CONFIG 15'h0000
`define SRP_OFF_CHIP_TYPE_CODE 15'h0003
`define SRP_OFF_PRODUCT_ID_LOW 15'h0004
`define SRP_OFF_PRODUCT_ID_HIGH 15'h0005
`define SRP_OFF_GRADE_AND_REVISION 15'h0006
`define SRP_OFF_TUNING_UPDATE 15'h0113
`define SRP_OFF_STAGE_BASE 15'h0114
`define SRP_STAGE_BYTES 8
`define SRP_STAGE_SPAN 15'h0008

// ----------------------------------------------------------------------------
// Field positions of interface_config, each setting held by a mirrored pair, and of the tuning update request bit
// ----------------------------------------------------------------------------
`define SRP_BIT_SOFT_RESET_HI 7
`define SRP_BIT_LSB_FIRST_HI 6
`define SRP_BIT_ADDR_INC_HI 5
`define SRP_BIT_OUT_PIN_HI 4
`define SRP_BIT_OUT_PIN_LO 3
`define SRP_BIT_ADDR_INC_LO 2
`define SRP_BIT_LSB_FIRST_LO 1
`define SRP_BIT_SOFT_RESET_LO 0
`define SRP_BIT_TUNING_UPDATE 0

// ----------------------------------------------------------------------------
// Reset values and frame counts
// ----------------------------------------------------------------------------
`define SRP_RST_SETTING 1'b0
`define SRP_RST_BYTE 8'h00
`define SRP_INSTR_LAST 4'hf
`define SRP_NIBBLE_LAST 3'h3
`define SRP_BYTE_LAST 3'h7

`endif

//--- hdl/srp_sync.v
// Purpose: Two flip-flop synchroniser for a group of asynchronous inputs.
// Assumes: Each bit is an independent level from outside the clock domain.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps

module srp_sync #(
    parameter W = 3
) (
    input wire clk_i,
    input wire rst_i,
    input wire [W-1:0] async_i,
    input wire [W-1:0] rst_val_i,
    output wire [W-1:0] sync_o
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    // ------------------------------------------------------------------------
    // Synchroniser stages
    // ------------------------------------------------------------------------
    // Both stages clear to zero; bits set in rst_val_i are inverted on the way in and out.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i ^ rst_val_i;
            sync_q <= meta_q;
        end
    end

    // Restore the true polarity of each bit.
    assign sync_o = sync_q ^ rst_val_i;

endmodule // srp_sync

//--- hdl/srp_port.v
// Purpose: Serial register port: instruction/data framing, config and ID regs.
// Assumes: One 10 MHz clock; serial clock, select and data arrive as pins.
// Notes: Serial clock edges are found by oversampling after synchronising.
//        Register zero, the ID bytes and the tuning bytes live here; other addresses go outward.
//
// Behaviour
// - First 16 rising serial clock edges after select low form the instruction.
// - Select high then low restarts bit counter and state at instruction start.
// - Data phase is whole bytes, eight serial clocks per byte.
// - Writes take effect at last bit, register zero at fourth bit; tuning registers wait for update request.
// - Instruction bit 15 one means read, zero means write.
// - Instruction bits 14..0 give the starting register address.
// - After each byte address steps up if increment set, else down.
// - Inputs sampled on rising serial clock, read data changes on falling.
// - Shared data pin released while select is high.
// - Bit order set by register zero bits 6 and 1, reset to MSB first.
// - MSB first sends direction, address, data high first; LSB first reversed.
// - Output-active bits one send read data on the separate output pin.
// - Register zero writes use first data nibble only, in either order.
// - Register zero holds soft reset at bits 0 and 7.
// - Chip_type_code returns a fixed chip type code.
// - Product_id_high and 0x004 return product identifier high and low bytes.
// - Grade_and_revision returns grade in upper nibble, revision in lower.
`timescale 1ns/1ps
`include "srp_defines.vh"

module srp_port #(
    parameter [7:0] CHIP_TYPE = 8'h5a,     // Arbitrary value.
    parameter [15:0] PRODUCT_ID = 16'h1357, // Arbitrary value.
    parameter [3:0] GRADE = 4'h1,          // Arbitrary value.
    parameter [3:0] REVISION = 4'h2        // Arbitrary value.
) (
    input wire clk_i,
    input wire rst_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire sdio_i,
    output wire sdio_o,
    output wire sdio_oe_o,
    output wire serial_out_pin_o,
    output wire serial_out_pin_oe_o,
    output wire soft_reset_o,
    output wire wr_strobe_o,
    output wire [14:0] wr_addr_o,
    output wire [7:0] wr_data_o,
    output wire [14:0] rd_addr_o,
    input wire [7:0] rd_data_i,
    output wire [47:0] freq_tuning_word_o,
    output wire [15:0] phase_accumulator_osc_offset_o
);

    // ------------------------------------------------------------------------
    // Pin synchronisation and serial clock edge detection
    // ------------------------------------------------------------------------
    wire [2:0] pins_s;
    wire sclk_s;
    wire cs_n_s;
    wire sdi_s;
    reg sclk_prev_q;
    wire sclk_rise;
    wire sclk_fall;

    // Select idles high, so its synchroniser resets to one.
    srp_sync #(
        .W(3)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({cs_n_i, sclk_i, sdio_i}),
        .rst_val_i(3'h4),
        .sync_o(pins_s)
    );

    // Data and clock pass the same two stages, so each sampled data bit
    // stays aligned with the serial clock edge that frames it.
    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign sdi_s = pins_s[0];

    // Previous serial clock level for edge detection.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    // Edges only count while select is low.
    // A fall seen after deselect therefore never moves the read shifter.
    assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;

    // ------------------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------------------
    reg [3:0] instr_cnt_q;
    reg data_ph_q;
    reg [15:0] instr_q;
    reg read_q;
    reg [14:0] addr_q;
    reg [2:0] bit_idx_q;
    reg [7:0] shift_q;
    reg [2:0] nib_q;
    reg load_q;
    reg [7:0] rd_byte_q;
    reg out_q;
    reg out_act_q;
    reg wr_strobe_q;
    reg [14:0] wr_addr_q;
    reg [7:0] wr_data_q;

    // Register zero settings, one flop per mirrored pair.
    // A setting written mid-frame applies to the rest of that frame.
    reg srst_q;
    reg lsb_first_q;
    reg addr_inc_q;
    reg out_pin_sel_q;

    wire [15:0] instr_nx;
    wire [7:0] byte_nx;
    wire [14:0] addr_step;
    wire cfg_nib_hit;

    // Shift direction follows the bit order so fields always land in place.
    assign instr_nx = lsb_first_q ? {sdi_s, instr_q[15:1]} : {instr_q[14:0], sdi_s};
    assign byte_nx = lsb_first_q ? {sdi_s, shift_q[7:1]} : {shift_q[6:0], sdi_s};

    // Next address of a multibyte transfer.
    assign addr_step = addr_inc_q ? (addr_q + 15'h0001) : (addr_q - 15'h0001);

    // Fourth data bit of a write aimed at register zero.
    assign cfg_nib_hit = (bit_idx_q == `SRP_NIBBLE_LAST) && !read_q
        && (addr_q == `SRP_OFF_INTERFACE_CONFIG);

    // ------------------------------------------------------------------------
    // Serial protocol engine
    // ------------------------------------------------------------------------
    // Collects the instruction, then whole data bytes, and steps the address.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            instr_cnt_q <= 4'h0;
            data_ph_q <= 1'b0;
            instr_q <= 16'h0000;
            read_q <= 1'b0;
            addr_q <= 15'h0000;
            bit_idx_q <= 3'h0;
            shift_q <= `SRP_RST_BYTE;
            nib_q <= 3'h0;
            load_q <= 1'b0;
            wr_strobe_q <= 1'b0;
            wr_addr_q <= 15'h0000;
            wr_data_q <= `SRP_RST_BYTE;
            srst_q <= `SRP_RST_SETTING;
            lsb_first_q <= `SRP_RST_SETTING;
            addr_inc_q <= `SRP_RST_SETTING;
            out_pin_sel_q <= `SRP_RST_SETTING;
        end else begin
            wr_strobe_q <= 1'b0;
            load_q <= 1'b0;
            if (cs_n_s) begin
                // Deselect abandons the frame and rearms the instruction phase.
                instr_cnt_q <= 4'h0;
                data_ph_q <= 1'b0;
                bit_idx_q <= 3'h0;
                read_q <= 1'b0;
            end else if (sclk_rise && !data_ph_q) begin
                instr_q <= instr_nx;
                instr_cnt_q <= instr_cnt_q + 4'h1;
                if (instr_cnt_q == `SRP_INSTR_LAST) begin
                    // The sixteenth edge closes the instruction.
                    data_ph_q <= 1'b1;
                    bit_idx_q <= 3'h0;
                    read_q <= instr_nx[15];
                    addr_q <= instr_nx[14:0];
                    load_q <= instr_nx[15];
                end
            end else if (sclk_rise) begin
                shift_q <= byte_nx;
                nib_q <= {nib_q[1:0], sdi_s};
                bit_idx_q <= bit_idx_q + 3'h1;
                if (cfg_nib_hit) begin
                    // First four bits received are reset, order, step, output.
                    // Acting on the first nibble leaves serial clocks in the byte
                    // after a soft reset, so the frame still ends cleanly.
                    srst_q <= nib_q[2];
                    if (nib_q[2]) begin
                        lsb_first_q <= `SRP_RST_SETTING;
                        addr_inc_q <= `SRP_RST_SETTING;
                        out_pin_sel_q <= `SRP_RST_SETTING;
                    end else begin
                        lsb_first_q <= nib_q[1];
                        addr_inc_q <= nib_q[0];
                        out_pin_sel_q <= sdi_s;
                    end
                end
                if (bit_idx_q == `SRP_BYTE_LAST) begin
                    // Byte complete: commit a write and move to the next address.
                    if (!read_q && addr_q != `SRP_OFF_INTERFACE_CONFIG) begin
                        wr_strobe_q <= 1'b1;
                        wr_addr_q <= addr_q;
                        wr_data_q <= byte_nx;
                    end
                    addr_q <= addr_step;
                    load_q <= read_q;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Tuning staging registers and update request
    // ------------------------------------------------------------------------
    reg [8*`SRP_STAGE_BYTES-1:0] stage_q;
    reg [8*`SRP_STAGE_BYTES-1:0] live_q;
    wire stage_hit;
    wire tune_hit;
    wire [14:0] stage_off;

    assign stage_off = wr_addr_q - `SRP_OFF_STAGE_BASE;
    assign stage_hit = (wr_addr_q >= `SRP_OFF_STAGE_BASE)
        && (stage_off < `SRP_STAGE_SPAN);
    assign tune_hit = (wr_addr_q == `SRP_OFF_TUNING_UPDATE);

    genvar gi;
    generate
        for (gi = 0; gi < `SRP_STAGE_BYTES; gi = gi + 1) begin : g_stage
            // Each staged byte loads on its write but is not yet in effect.
            always @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    stage_q[8*gi+7:8*gi] <= `SRP_RST_BYTE;
                end else if (srst_q) begin
                    stage_q[8*gi+7:8*gi] <= `SRP_RST_BYTE;
                end else if (wr_strobe_q && stage_hit && stage_off == gi) begin
                    stage_q[8*gi+7:8*gi] <= wr_data_q;
                end
            end
        end
    endgenerate

    // Staged words become live only when the update request bit is written.
    // Copying every byte at once keeps a multibyte tuning word coherent.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            live_q <= {8*`SRP_STAGE_BYTES{1'b0}};
        end else if (srst_q) begin
            live_q <= {8*`SRP_STAGE_BYTES{1'b0}};
        end else if (wr_strobe_q && tune_hit && wr_data_q[`SRP_BIT_TUNING_UPDATE]) begin
            live_q <= stage_q;
        end
    end

    assign freq_tuning_word_o = live_q[47:0];
    assign phase_accumulator_osc_offset_o = live_q[63:48];

    // ------------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------------
    reg [7:0] rd_mux;
    reg [7:0] stage_rd;
    integer k;
    wire stage_rd_hit;

    // Address falls inside the tuning staging bytes.
    assign stage_rd_hit = (addr_q >= `SRP_OFF_STAGE_BASE)
        && (addr_q < `SRP_OFF_STAGE_BASE + `SRP_STAGE_SPAN);

    // Picks the byte addressed for the next read slot.
    always @* begin
        stage_rd = `SRP_RST_BYTE;
        for (k = 0; k < `SRP_STAGE_BYTES; k = k + 1) begin
            if (addr_q == `SRP_OFF_STAGE_BASE + k[14:0]) begin
                stage_rd = stage_q[8*k +: 8];
            end
        end
        if (addr_q == `SRP_OFF_INTERFACE_CONFIG) begin
            rd_mux = {srst_q, lsb_first_q, addr_inc_q, out_pin_sel_q,
                out_pin_sel_q, addr_inc_q, lsb_first_q, srst_q};
        end else if (addr_q == `SRP_OFF_CHIP_TYPE_CODE) begin
            rd_mux = CHIP_TYPE;
        end else if (addr_q == `SRP_OFF_PRODUCT_ID_LOW) begin
            rd_mux = PRODUCT_ID[7:0];
        end else if (addr_q == `SRP_OFF_PRODUCT_ID_HIGH) begin
            rd_mux = PRODUCT_ID[15:8];
        end else if (addr_q == `SRP_OFF_GRADE_AND_REVISION) begin
            rd_mux = {GRADE, REVISION};
        end else if (addr_q == `SRP_OFF_TUNING_UPDATE) begin
            // The update request acts once and is not held, so it reads zero.
            rd_mux = `SRP_RST_BYTE;
        end else if (stage_rd_hit) begin
            rd_mux = stage_rd;
        end else begin
            rd_mux = rd_data_i;
        end
    end

    // ------------------------------------------------------------------------
    // Read output shifter
    // ------------------------------------------------------------------------
    // Loads a byte one cycle after its address settles, shifts on falling edges.
    // An edge needs three clocks through sync and detect, so the load always
    // lands before the first fall of the byte's slot.
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_byte_q <= `SRP_RST_BYTE;
            out_q <= 1'b0;
            out_act_q <= 1'b0;
        end else begin
            if (load_q) begin
                rd_byte_q <= rd_mux;
            end
            if (cs_n_s) begin
                out_act_q <= 1'b0;
            end else if (sclk_fall && data_ph_q && read_q) begin
                out_act_q <= 1'b1;
                if (lsb_first_q) begin
                    out_q <= rd_byte_q[bit_idx_q];
                end else begin
                    out_q <= rd_byte_q[3'h7 - bit_idx_q];
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------------
    // Read data leaves on the shared pin or the separate output pin.
    // Both pins carry the same bit; only the enables decide which is live.
    assign sdio_o = out_q;
    assign sdio_oe_o = out_act_q & ~out_pin_sel_q & ~cs_n_s;
    assign serial_out_pin_o = out_q;
    assign serial_out_pin_oe_o = out_act_q & out_pin_sel_q & ~cs_n_s;

    // Outward register write port for registers held elsewhere.
    // Staged tuning bytes and the update request never leave the block.
    assign wr_strobe_o = wr_strobe_q & ~stage_hit & ~tune_hit;
    assign wr_addr_o = wr_addr_q;
    assign wr_data_o = wr_data_q;
    assign rd_addr_o = addr_q;
    assign soft_reset_o = srst_q;

endmodule // srp_port

//--- bench/srp_props.sv
// Purpose: Checker of the serial register port pin behaviour.
// Assumes: Bound to srp_port; select and serial clock pass two sync flops.
// Notes: Look-back of two or three clocks covers that synchroniser delay.
`timescale 1ns/1ps

module srp_props (
    input wire clk_i,
    input wire rst_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire sdio_o,
    input wire sdio_oe_o,
    input wire serial_out_pin_oe_o,
    input wire soft_reset_o,
    input wire wr_strobe_o,
    input wire [47:0] freq_tuning_word_o,
    input wire [15:0] phase_accumulator_osc_offset_o
);
    // ------------------------------------------------------------
    // Sequences and properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Select held high long enough to be seen.
    sequence s_deselected;
        cs_n_i [*4];
    endsequence
    // No second strobe within one serial clock period.
    sequence s_quiet;
        !wr_strobe_o [*8];
    endsequence

    property p_idle_float;
        s_deselected |-> !sdio_oe_o && !serial_out_pin_oe_o;
    endproperty
    a_idle_float: assert property (p_idle_float)
        else $error("data pin driven while deselected");
    property p_one_pin;
        !(sdio_oe_o && serial_out_pin_oe_o);
    endproperty
    a_one_pin: assert property (p_one_pin)
        else $error("both output pins driven");
    property p_drive_on_fall;
        $rose(sdio_oe_o || serial_out_pin_oe_o) |-> !$past(sclk_i, 2);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall)
        else $error("read drive began while serial clock high");
    property p_shift_on_fall;
        (sdio_oe_o || serial_out_pin_oe_o) && $changed(sdio_o) |-> !$past(sclk_i, 2);
    endproperty
    a_shift_on_fall: assert property (p_shift_on_fall)
        else $error("read bit changed while serial clock high");
    property p_strobe_gap;
        wr_strobe_o |=> s_quiet;
    endproperty
    a_strobe_gap: assert property (p_strobe_gap)
        else $error("write strobe longer than one pulse per byte");
    property p_strobe_frame;
        wr_strobe_o |-> !$past(cs_n_i, 3);
    endproperty
    a_strobe_frame: assert property (p_strobe_frame)
        else $error("write strobe outside a frame");
    property p_tune_frame;
        $changed(freq_tuning_word_o) || $changed(phase_accumulator_osc_offset_o)
            |-> !$past(cs_n_i, 3);
    endproperty
    a_tune_frame: assert property (p_tune_frame)
        else $error("tuning output changed outside a frame");
    property p_soft_frame;
        $changed(soft_reset_o) |-> !$past(cs_n_i, 3);
    endproperty
    a_soft_frame: assert property (p_soft_frame)
        else $error("soft reset changed outside a frame");
endmodule // srp_props

bind srp_port srp_props u_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o),
    .serial_out_pin_oe_o(serial_out_pin_oe_o),
    .soft_reset_o(soft_reset_o),
    .wr_strobe_o(wr_strobe_o),
    .freq_tuning_word_o(freq_tuning_word_o),
    .phase_accumulator_osc_offset_o(phase_accumulator_osc_offset_o)
);

//--- bench/srp_host.sv
// Purpose: Host serial master model driving clock, select and data.
// Assumes: Clock period 100 ns; serial clock 800 ns, idle low.
// Notes: An undriven data line shows the inverse of the last host bit.
`timescale 1ns/1ps

module srp_host (
    input wire clk_i,
    input wire sdio_oe_i,
    input wire sdio_dev_i,
    input wire sep_i,
    output reg sclk_o,
    output reg cs_n_o,
    output wire pin_o
);
    reg mosi_q;
    reg drv_q;

    // Shared pin level from both parties' enables.
    assign pin_o = sdio_oe_i ? sdio_dev_i : (drv_q ? mosi_q : ~mosi_q);

    // Idle levels at time zero.
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_q = 1'b0;
        drv_q = 1'b0;
    end

    // One bit: data set with the fall, read bit taken just before the rise.
    task automatic shift(input logic b, input logic four, output logic r);
        @(posedge clk_i);
        sclk_o <= 1'b0;
        mosi_q <= b;
        repeat (4) @(posedge clk_i);
        r = four ? sep_i : pin_o;
        sclk_o <= 1'b1;
        repeat (3) @(posedge clk_i);
    endtask

    // Whole frame; a nonzero cut stops after that many bits.
    task automatic xfer(input logic rw, input logic [14:0] a, input int n,
                        input logic [15:0] wd, input logic lsb, input logic four,
                        input int cut, output logic [15:0] rd);
        logic [15:0] ins;
        logic r;
        int k;
        ins = {rw, a};
        rd = 16'h0000;
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        drv_q <= 1'b1;
        for (int i = 0; i < 16 + 8 * n && (cut == 0 || i < cut); i++) begin
            if (i == 16) begin
                drv_q <= ~rw | four;
            end
            k = (i - 16) / 8 * 8 + (lsb ? (i - 16) % 8 : 7 - (i - 16) % 8);
            if (i < 16) begin
                shift(lsb ? ins[i] : ins[15 - i], four, r);
            end else begin
                shift(wd[k], four, r);
                rd[k] = r;
            end
        end
        @(posedge clk_i);
        sclk_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        cs_n_o <= 1'b1;
        drv_q <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask
endmodule // srp_host

//--- bench/serial_register_port_test.sv
// Purpose: Self-checking bench of the serial register port.
// Assumes: Host model drives the serial pins; outside bytes are the address low byte XOR a5.
// Notes: Table rows read register zero, the ID registers and one outside byte; special cases follow by hand.
`timescale 1ns/1ps

module serial_register_port_test;
    localparam [7:0] CT = 8'h6b; // Arbitrary value.
    localparam [15:0] PID = 16'h2468; // Arbitrary value.
    localparam [3:0] GR = 4'h3; // Arbitrary value.
    localparam [3:0] RV = 4'h4; // Arbitrary value.
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    wire sclk, cs_n, pin, sdio_o, sdio_oe, sep_pin, sep_oe, soft_rst, wr_stb;
    wire [14:0] wr_addr, rd_addr;
    wire [7:0] wr_data, rd_data;
    wire [47:0] tune_word;
    wire [15:0] phase;
    integer fails = 0;
    integer cmp_count = 0;
    logic [22:0] wq[$];
    logic [15:0] rd;
    logic [14:0] row_a[6] = '{15'h0000, 15'h0003, 15'h0004, 15'h0005, 15'h0006, 15'h0010};
    logic [7:0] row_e[6] = '{8'h00, CT, PID[7:0], PID[15:8], {GR, RV}, 8'hb5};

    // ------------------------------------------------------------
    // Clock, outside register data and strobe capture
    // ------------------------------------------------------------
    always #50 clk_i = ~clk_i;
    assign rd_data = rd_addr[7:0] ^ 8'ha5;
    always @(posedge clk_i) begin
        if (wr_stb === 1'b1) begin
            wq.push_back({wr_addr, wr_data});
        end
    end

    srp_port #(.CHIP_TYPE(CT), .PRODUCT_ID(PID), .GRADE(GR), .REVISION(RV)) uut (
        .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(pin),
        .sdio_o(sdio_o), .sdio_oe_o(sdio_oe), .serial_out_pin_o(sep_pin),
        .serial_out_pin_oe_o(sep_oe), .soft_reset_o(soft_rst), .wr_strobe_o(wr_stb),
        .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_addr_o(rd_addr),
        .rd_data_i(rd_data), .freq_tuning_word_o(tune_word),
        .phase_accumulator_osc_offset_o(phase));
    srp_host host (.clk_i(clk_i), .sdio_oe_i(sdio_oe), .sdio_dev_i(sdio_o), .sep_i(sep_pin),
        .sclk_o(sclk), .cs_n_o(cs_n), .pin_o(pin));

    // Compare one value and count it.
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Print counts and verdict, then stop.
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Cut a hang short.
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        complete_run();
    end

    // Main sequence.
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        check(tune_word, 48'h0000_0000_0000);
        for (int i = 0; i < 6; i++) begin
            host.xfer(1'b1, row_a[i], 1, 16'h0000, 1'b0, 1'b0, 0, rd);
            check(rd[7:0], row_e[i]);
        end
        host.xfer(1'b0, 15'h0051, 2, 16'hc3a5, 1'b0, 1'b0, 0, rd);
        check(wq.size(), 2);
        check(wq[0], {15'h0051, 8'ha5});
        check(wq[1], {15'h0050, 8'hc3});
        wq.delete();
        host.xfer(1'b0, 15'h0060, 1, 16'h00ff, 1'b0, 1'b0, 20, rd);
        host.xfer(1'b0, 15'h0061, 1, 16'h0077, 1'b0, 1'b0, 0, rd);
        check(wq.size(), 1);
        check(wq[0], {15'h0061, 8'h77});
        host.xfer(1'b0, 15'h011a, 2, 16'h3322, 1'b0, 1'b0, 0, rd);
        host.xfer(1'b0, 15'h0114, 1, 16'h0011, 1'b0, 1'b0, 0, rd);
        check(tune_word, 48'h0000_0000_0000);
        check(phase, 16'h0000);
        host.xfer(1'b0, 15'h0113, 1, 16'h0001, 1'b0, 1'b0, 0, rd);
        check(tune_word, 48'h3300_0000_0011);
        check(phase, 16'h0022);
        host.xfer(1'b0, 15'h0000, 1, 16'h00bd, 1'b0, 1'b0, 0, rd);
        check(soft_rst, 1'b1);
        check(tune_word, 48'h0000_0000_0000);
        host.xfer(1'b0, 15'h0000, 1, 16'h003c, 1'b0, 1'b0, 0, rd);
        check(soft_rst, 1'b0);
        host.xfer(1'b1, 15'h0004, 2, 16'h0000, 1'b0, 1'b1, 0, rd);
        check(rd, PID);
        host.xfer(1'b0, 15'h0000, 1, 16'h003f, 1'b0, 1'b1, 0, rd);
        host.xfer(1'b1, 15'h0000, 1, 16'h0000, 1'b0, 1'b1, 0, rd);
        check(rd[7:0], 8'h3c);
        host.xfer(1'b0, 15'h0000, 1, 16'h007e, 1'b0, 1'b1, 0, rd);
        host.xfer(1'b1, 15'h0000, 1, 16'h0000, 1'b1, 1'b1, 0, rd);
        check(rd[7:0], 8'h7e);
        wq.delete();
        host.xfer(1'b0, 15'h0070, 1, 16'h00a1, 1'b1, 1'b1, 0, rd);
        check(wq[0], {15'h0070, 8'ha1});
        host.xfer(1'b1, 15'h0006, 1, 16'h0000, 1'b1, 1'b1, 0, rd);
        check(rd[7:0], {GR, RV});
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        host.xfer(1'b1, 15'h0000, 1, 16'h0000, 1'b0, 1'b0, 0, rd);
        check(rd[7:0], 8'h00);
        complete_run();
    end
endmodule // serial_register_port_test
